/* hw/fpe_pkg.sv */
// Constants shared by the frequency protection block and its stage timer
package fpe_pkg;
  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // Drop-off hold, 200 ms, counted in time-base ticks
  localparam int HOLD_MS = 200;
  localparam logic [7:0] HOLD_TICKS = 8'(HOLD_MS * 1000 / TICK_US);
  // Operate time step of 0.1 s, counted in ticks
  localparam int OPT_STEP_MS = 100;
  localparam logic [15:0] OPT_STEP_TICKS = 16'(OPT_STEP_MS * 1000 / TICK_US);
  // Operate time setting in 0.1 s units: 0.1 .. 60.0 s
  localparam logic [9:0] OPT_MIN = 10'h001;
  localparam logic [9:0] OPT_MAX = 10'h258;
  localparam logic [9:0] OPT_RST = 10'h00A;
  // Threshold magnitude in 0.1 Hz units: 0.5 .. 5.0 Hz
  localparam logic [5:0] THR_MIN = 6'h05;
  localparam logic [5:0] THR_MAX = 6'h32;
  localparam logic [5:0] THR_RST = 6'h05;
  // Frequency in 0.01 Hz units, voltage in 0.1 V units
  localparam logic [17:0] THR_SCALE = 18'h0000A;
  localparam logic [15:0] V_MIN = 16'h015E;
  localparam logic [15:0] RATED_RST = 16'h1388;
  // Stage counts
  localparam int NSTG = 6;
  localparam int NUF = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_USE = 8'h00;
  localparam logic [7:0] OFS_RATED = 8'h04;
  localparam logic [7:0] OFS_CFG0 = 8'h08;
  localparam logic [7:0] OFS_CFG5 = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_ISTAT = 8'h24;
  localparam logic [7:0] OFS_IMASK = 8'h28;
  localparam logic [7:0] OFS_MEAS = 8'h2C;
  // Field positions
  localparam int CFG_OPT_LSB = 0;
  localparam int CFG_THR_LSB = 16;
  localparam int STAT_PICK_LSB = 8;
  localparam int MEAS_VOLT_LSB = 16;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/fpe_stage.sv */
// One frequency stage: operate timer, drop-off hold and use gating
`timescale 1ns/1ps
`default_nettype none
module fpe_stage (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Time base and condition
  input wire logic tick,
  input wire logic pickup,
  // Settings
  input wire logic use_on,
  input wire logic [9:0] op_time,
  // Result
  output logic trip
);
  typedef struct packed {
    logic [15:0] op_cnt;
    logic [7:0] hold;
    logic trip;
  } fpe_stg_t;

  fpe_stg_t s;
  fpe_stg_t n;
  logic [15:0] lim;

  always_comb begin
    n = s;
    lim = 16'(op_time) * fpe_pkg::OPT_STEP_TICKS;
    if (!use_on) begin
      n = '0;
    end else if (pickup) begin
      if (s.trip) begin
        n.hold = fpe_pkg::HOLD_TICKS;
      end else if (tick) begin
        if (s.op_cnt + 16'h0001 >= lim) begin
          n.trip = 1'b1;
          n.hold = fpe_pkg::HOLD_TICKS;
          n.op_cnt = '0;
        end else begin
          n.op_cnt = s.op_cnt + 16'h0001;
        end
      end
    end else begin
      n.op_cnt = '0;
      if (s.trip && tick) begin
        if (s.hold <= 8'h01) begin
          n.trip = 1'b0;
          n.hold = '0;
        end else begin
          n.hold = s.hold - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign trip = s.trip;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_USE_OFF: assert property (!use_on |=> !trip)
    else $error("stage tripped while not in use");
  AST_TRIP_AFTER_TIME: assert property ($rose(trip) |-> $past(pickup) && $past(tick) &&
    ($past(s.op_cnt) + 16'h0001 >= $past(lim)))
    else $error("trip rose before the operate time ran out");
  AST_OP_RESET: assert property (use_on && !pickup |=> s.op_cnt == 16'h0000)
    else $error("operate timer not cleared on pickup loss");
  AST_HOLD_RELOAD: assert property (use_on && pickup && trip |=> s.hold == fpe_pkg::HOLD_TICKS)
    else $error("hold not restarted on returning pickup");
  AST_HOLD_KEEP: assert property (use_on && !pickup && trip && tick && s.hold > 8'h01 |=>
    trip && s.hold == $past(s.hold) - 8'h01)
    else $error("trip dropped before the hold ran out");
  COV_TRIP: cover property ($rose(trip));
  COV_RESTART: cover property (trip && !pickup ##1 trip && pickup);
endmodule
`default_nettype wire

/* hw/fpe_top.sv */
// Frequency protection: three underfrequency and three overfrequency stages
//
// What this block does
// - Three separate underfrequency stages, each with own use, threshold and time.
// - Underfrequency picks up only while AB-derived frequency is below its threshold.
// - Underfrequency pickup also needs AB voltage of at least 35 V.
// - Underfrequency trip only after pickup lasts the operate time, 0.1 to 60 s.
// - Underfrequency trip held 200 ms after pickup clears.
// - Underfrequency trip never asserts while its use setting is off.
// - Underfrequency threshold is rated frequency minus 0.5 to 5.0 Hz.
// - Three separate overfrequency stages, each with own use, threshold and time.
// - Overfrequency picks up above rated plus 0.5 to 5.0 Hz, voltage above 35 V.
// - Overfrequency trip only after pickup lasts the operate time, 0.1 to 60 s.
// - Overfrequency trip held 200 ms after pickup ends.
// - Overfrequency trip suppressed while its use setting is off.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fpe_top #(
  parameter int TICK_CYC = fpe_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Measurement front end
  input wire logic meas_valid,
  input wire logic [15:0] meas_freq,
  input wire logic [15:0] meas_volt,
  // Trip outputs and interrupt
  output logic [2:0] underfreq_trip,
  output logic [2:0] overfreq_trip,
  output logic irq
);
  typedef struct packed {
    logic aw_ok;
    logic [7:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] use_on;
    logic [15:0] rated;
    logic [5:0][9:0] opt;
    logic [5:0][5:0] thr;
    logic [15:0] freq;
    logic [15:0] volt;
    logic meas_ok;
    logic [5:0] pick;
    logic [5:0] trip_d;
    logic [5:0] ist;
    logic [5:0] imask;
    logic irq;
    logic [15:0] div;
    logic tick;
  } fpe_top_t;

  fpe_top_t s;
  fpe_top_t n;
  logic [5:0] trip;
  logic [5:0] clr;
  logic [31:0] wtmp;
  logic [17:0] lim_uf [fpe_pkg::NSTG];
  logic [17:0] lim_of [fpe_pkg::NSTG];

  // Byte lanes merge into the current value so a partial write keeps other fields
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Stage setting words sit on a four-byte stride from the first one
  function automatic logic is_cfg(input logic [7:0] a);
    return a >= fpe_pkg::OFS_CFG0 && a <= fpe_pkg::OFS_CFG5 && a[1:0] == 2'h0;
  endfunction

  function automatic logic [2:0] cfg_sel(input logic [7:0] a);
    logic [7:0] d;
    d = a - fpe_pkg::OFS_CFG0;
    return d[4:2];
  endfunction

  function automatic logic [9:0] clamp_opt(input logic [9:0] v);
    if (v < fpe_pkg::OPT_MIN) begin
      return fpe_pkg::OPT_MIN;
    end else if (v > fpe_pkg::OPT_MAX) begin
      return fpe_pkg::OPT_MAX;
    end
    return v;
  endfunction

  function automatic logic [5:0] clamp_thr(input logic [5:0] v);
    if (v < fpe_pkg::THR_MIN) begin
      return fpe_pkg::THR_MIN;
    end else if (v > fpe_pkg::THR_MAX) begin
      return fpe_pkg::THR_MAX;
    end
    return v;
  endfunction

  always_comb begin
    n = s;
    clr = '0;
    wtmp = '0;
    // Time base tick
    n.tick = 1'b0;
    if (s.div == 16'(TICK_CYC - 1)) begin
      n.div = '0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 16'h0001;
    end
    if (meas_valid) begin
      n.freq = meas_freq;
      n.volt = meas_volt;
      n.meas_ok = 1'b1;
    end
    // Threshold is an offset in 0.1 Hz steps about rated frequency
    // Signed compare stops a low rated value from wrapping the underfrequency limit
    for (int k = 0; k < fpe_pkg::NSTG; k++) begin
      lim_uf[k] = {2'h0, s.rated} - 18'(s.thr[k]) * fpe_pkg::THR_SCALE;
      lim_of[k] = {2'h0, s.rated} + 18'(s.thr[k]) * fpe_pkg::THR_SCALE;
      if (k < fpe_pkg::NUF) begin
        // below threshold, voltage at least 35 V, negative offset
        n.pick[k] = s.meas_ok && ($signed(lim_uf[k]) > $signed({2'h0, s.freq})) &&
                    (s.volt >= fpe_pkg::V_MIN);
      end else begin
        // above threshold, voltage strictly above 35 V
        n.pick[k] = s.meas_ok && ({2'h0, s.freq} > lim_of[k]) && (s.volt > fpe_pkg::V_MIN);
      end
    end
    // Write address and data are taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_ok = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_ok = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = fpe_pkg::RESP_OKAY;
      case (s.aw_a)
        fpe_pkg::OFS_USE: begin
          wtmp = wmerge({26'h0, s.use_on}, s.w_d, s.w_s);
          n.use_on = wtmp[5:0];
        end
        fpe_pkg::OFS_RATED: begin
          wtmp = wmerge({16'h0, s.rated}, s.w_d, s.w_s);
          n.rated = wtmp[15:0];
        end
        fpe_pkg::OFS_ISTAT: begin
          wtmp = wmerge(32'h0, s.w_d, s.w_s);
          clr = wtmp[5:0];
        end
        fpe_pkg::OFS_IMASK: begin
          wtmp = wmerge({26'h0, s.imask}, s.w_d, s.w_s);
          n.imask = wtmp[5:0];
        end
        fpe_pkg::OFS_STAT, fpe_pkg::OFS_MEAS: begin
          n.bresp = fpe_pkg::RESP_OKAY;
        end
        default: begin
          if (is_cfg(s.aw_a)) begin
            wtmp = wmerge({10'h0, s.thr[cfg_sel(s.aw_a)], 6'h0, s.opt[cfg_sel(s.aw_a)]}, s.w_d, s.w_s);
            // Out-of-range settings are clamped so a stage never runs on nonsense
            n.opt[cfg_sel(s.aw_a)] = clamp_opt(wtmp[fpe_pkg::CFG_OPT_LSB +: 10]);
            n.thr[cfg_sel(s.aw_a)] = clamp_thr(wtmp[fpe_pkg::CFG_THR_LSB +: 6]);
          end else begin
            n.bresp = fpe_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // Read channel
    // Read data is registered so the bus never sees a half-updated word
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = fpe_pkg::RESP_OKAY;
      n.rdata = '0;
      case (s_axi_araddr)
        fpe_pkg::OFS_USE: n.rdata = {26'h0, s.use_on};
        fpe_pkg::OFS_RATED: n.rdata = {16'h0, s.rated};
        fpe_pkg::OFS_STAT: n.rdata = {18'h0, s.pick, 2'h0, trip};
        fpe_pkg::OFS_ISTAT: n.rdata = {26'h0, s.ist};
        fpe_pkg::OFS_IMASK: n.rdata = {26'h0, s.imask};
        fpe_pkg::OFS_MEAS: n.rdata = {s.volt, s.freq};
        default: begin
          if (is_cfg(s_axi_araddr)) begin
            n.rdata = {10'h0, s.thr[cfg_sel(s_axi_araddr)], 6'h0, s.opt[cfg_sel(s_axi_araddr)]};
          end else begin
            n.rresp = fpe_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // Trip rising edges are sticky; a new edge wins over a clear
    n.trip_d = trip;
    n.ist = (s.ist & ~clr) | (trip & ~s.trip_d);
    n.irq = |(n.ist & n.imask);
    // Ready follows the holding flops so a taken beat is never taken twice
    n.awready = !n.aw_ok;
    n.wready = !n.w_ok;
    n.arready = !n.rvalid;
  end

  // Settings leave reset at usable defaults so no stage times against zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.rated <= fpe_pkg::RATED_RST;
      for (int k = 0; k < fpe_pkg::NSTG; k++) begin
        s.opt[k] <= fpe_pkg::OPT_RST;
        s.thr[k] <= fpe_pkg::THR_RST;
      end
    end else begin
      s <= n;
    end
  end

  for (genvar k = 0; k < fpe_pkg::NSTG; k++) begin : g_stg
    fpe_stage u_stg (
      .mclk(mclk),
      .rstn(rstn),
      .tick(s.tick),
      .pickup(s.pick[k]),
      .use_on(s.use_on[k]),
      .op_time(s.opt[k]),
      .trip(trip[k])
    );
  end

  assign underfreq_trip = trip[2:0];
  assign overfreq_trip = trip[5:3];
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign irq = s.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_UF_VOLT_EDGE: assert property (s.meas_ok && s.volt == fpe_pkg::V_MIN &&
    {2'h0, s.freq} < lim_uf[0] && lim_uf[0] < 18'h10000 |=> s.pick[0])
    else $error("underfrequency did not pick up at exactly 35 V");
  AST_UF_LOW_VOLT: assert property (s.volt < fpe_pkg::V_MIN |=> s.pick[2:0] == 3'h0)
    else $error("underfrequency picked up below 35 V");
  AST_UF_FREQ: assert property ({2'h0, s.freq} >= lim_uf[1] |=> !s.pick[1])
    else $error("underfrequency picked up at or above threshold");
  AST_OF_VOLT_EDGE: assert property (s.volt <= fpe_pkg::V_MIN |=> s.pick[5:3] == 3'h0)
    else $error("overfrequency picked up at or below 35 V");
  AST_OF_FREQ: assert property (s.meas_ok && s.volt > fpe_pkg::V_MIN &&
    {2'h0, s.freq} > {2'h0, s.rated} + 18'(s.thr[3]) * fpe_pkg::THR_SCALE |=> s.pick[3])
    else $error("overfrequency missed pickup above threshold");
  AST_THR_RANGE: assert property (s.thr[0] >= fpe_pkg::THR_MIN && s.thr[0] <= fpe_pkg::THR_MAX)
    else $error("threshold setting out of range");
  AST_OF_USE: assert property (!s.use_on[4] |=> !overfreq_trip[1])
    else $error("overfrequency tripped while not in use");
  AST_OF_HOLD: assert property ($fell(s.pick[3]) && s.use_on[3] && trip[3] |->
    trip[3] [*8])
    else $error("overfrequency trip released without drop-off hold");
  AST_IRQ_LEVEL: assert property (s.irq == |(s.ist & s.imask))
    else $error("interrupt does not follow unmasked status");
  AST_B_HOLD: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
    else $error("write response withdrawn before it was taken");
  AST_UF_USE: assert property (!s.use_on[1] |=> !underfreq_trip[1])
    else $error("underfrequency tripped while not in use");
  AST_UF_HOLD: assert property ($fell(s.pick[0]) && s.use_on[0] && trip[0] |->
    trip[0] [*8])
    else $error("underfrequency trip released without drop-off hold");
  AST_UF_TIME: assert property ($rose(underfreq_trip[1]) |-> $past(s.pick[1]) && $past(s.tick))
    else $error("underfrequency trip rose off a tick or without pickup");
  AST_OF_TIME: assert property ($rose(overfreq_trip[0]) |->
    $past(s.pick[3]) && $past(s.use_on[3]) && $past(s.tick))
    else $error("overfrequency trip rose off a tick or without pickup");
  AST_OPT_RANGE: assert property (s.opt[3] >= fpe_pkg::OPT_MIN && s.opt[3] <= fpe_pkg::OPT_MAX)
    else $error("operate time setting out of range");
  AST_R_HOLD: assert property (s.rvalid && !s_axi_rready |=> s.rvalid && $stable(s.rdata))
    else $error("read data withdrawn before it was taken");
  AST_AR_GAP: assert property (s.rvalid |-> !s.arready)
    else $error("read address accepted while read data pending");
  AST_IST_SET: assert property (trip[0] && !s.trip_d[0] |=> s.ist[0])
    else $error("trip edge did not set its status bit");
  COV_UF_TRIP: cover property ($rose(underfreq_trip[0]));
  COV_OF_TRIP: cover property ($rose(overfreq_trip[2]));
  COV_IRQ: cover property ($rose(irq));
  COV_CLR_SET: cover property (|(clr & trip & ~s.trip_d));
endmodule
`default_nettype wire

/* tb/fpe_meas_model.sv */
// Measurement front end model: periodic strobe with frequency and voltage
`timescale 1ns/1ps
`default_nettype none
module fpe_meas_model #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Values to present
  input wire logic [15:0] set_freq,
  input wire logic [15:0] set_volt,
  // Front end outputs
  output logic meas_valid,
  output logic [15:0] meas_freq,
  output logic [15:0] meas_volt
);
  int cnt;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      meas_valid <= 1'b0;
      meas_freq <= 16'h0000;
      meas_volt <= 16'h0000;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_valid <= (cnt == PERIOD - 1);
      // Between strobes the values are junk, so the block must not use them
      meas_freq <= (cnt == PERIOD - 1) ? set_freq : ~meas_freq;
      meas_volt <= (cnt == PERIOD - 1) ? set_volt : ~meas_volt;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the frequency protection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [15:0] set_freq = 16'h1388;
  logic [15:0] set_volt = 16'h0190;
  logic awready, wready, bvalid, arready, rvalid, meas_valid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] meas_freq, meas_volt;
  logic [2:0] uf_trip, of_trip;
  logic [5:0] trips;
  int fails = 0;
  int tests_run = 0;
  assign trips = {of_trip, uf_trip};

  fpe_top #(.TICK_CYC(4)) dut (
    .mclk(mclk), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .meas_valid(meas_valid), .meas_freq(meas_freq), .meas_volt(meas_volt),
    .underfreq_trip(uf_trip), .overfreq_trip(of_trip), .irq(irq)
  );

  fpe_meas_model #(.PERIOD(4)) u_meas (
    .mclk(mclk), .rstn(rstn), .set_freq(set_freq), .set_volt(set_volt),
    .meas_valid(meas_valid), .meas_freq(meas_freq), .meas_volt(meas_volt)
  );

  always #12.5 mclk = ~mclk;

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    if (i == 40) begin
      fails++;
      stop_test();
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    if (i == 40) begin
      fails++;
      stop_test();
    end
  endtask

  // Trips must stay at exp for n cycles
  task hold_chk(input logic [5:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (trips !== exp) break;
    end
    chk({26'h0, trips}, {26'h0, exp});
  endtask

  // Trips must reach exp within n cycles
  task wait_trip(input logic [5:0] exp, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      if (trips === exp) break;
    end
    chk({26'h0, trips}, {26'h0, exp});
    if (i == n) stop_test();
  endtask

  task meas(input logic [15:0] f, input logic [15:0] v);
    @(posedge mclk);
    set_freq <= f;
    set_volt <= v;
  endtask

  logic [5:0] thr [3] = '{6'h05, 6'h0A, 6'h32};

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(fpe_pkg::OFS_USE, 32'h0, 2'h0);
    rd(fpe_pkg::OFS_RATED, 32'h00001388, 2'h0);
    rd(fpe_pkg::OFS_CFG0, 32'h0005000A, 2'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h30, 32'hFFFFFFFF, 2'h2);
    $display("test registers done");
    // Stages 1..3 of each kind get thresholds 0.5, 1.0 and 5.0 Hz, 0.1 s operate
    for (int k = 0; k < 6; k++) begin
      wr(fpe_pkg::OFS_CFG0 + 8'(4 * k), {10'h0, thr[k % 3], 6'h0, 10'h001}, 2'h0);
    end
    rd(fpe_pkg::OFS_CFG5, 32'h00320001, 2'h0);
    wr(fpe_pkg::OFS_IMASK, 32'h3F, 2'h0);
    wr(fpe_pkg::OFS_USE, 32'h3F, 2'h0);
    meas(16'h1355, 16'h015E);
    hold_chk(6'h00, 380);
    wait_trip(6'h01, 80);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    rd(fpe_pkg::OFS_ISTAT, 32'h01, 2'h0);
    wr(fpe_pkg::OFS_ISTAT, 32'h01, 2'h0);
    rd(fpe_pkg::OFS_ISTAT, 32'h00, 2'h0);
    chk(irq, 1'b0);
    meas(16'h1388, 16'h015E);
    hold_chk(6'h01, 780);
    wait_trip(6'h00, 80);
    $display("test underfreq trip done");
    meas(16'h1355, 16'h015E);
    wait_trip(6'h01, 480);
    meas(16'h1388, 16'h015E);
    hold_chk(6'h01, 400);
    meas(16'h1355, 16'h015E);
    hold_chk(6'h01, 40);
    meas(16'h1388, 16'h015E);
    hold_chk(6'h01, 760);
    wait_trip(6'h00, 100);
    meas(16'h1355, 16'h015E);
    hold_chk(6'h00, 300);
    meas(16'h1388, 16'h015E);
    hold_chk(6'h00, 20);
    meas(16'h1355, 16'h015E);
    hold_chk(6'h00, 330);
    wait_trip(6'h01, 120);
    meas(16'h1388, 16'h015E);
    wait_trip(6'h00, 900);
    $display("test timer restart done");
    meas(16'h1323, 16'h015D);
    hold_chk(6'h00, 450);
    meas(16'h1383, 16'h015E);
    hold_chk(6'h00, 450);
    meas(16'h1323, 16'h015E);
    wait_trip(6'h03, 480);
    wr(fpe_pkg::OFS_USE, 32'h3E, 2'h0);
    wait_trip(6'h02, 10);
    meas(16'h1388, 16'h015E);
    wait_trip(6'h00, 900);
    $display("test underfreq bounds done");
    wr(fpe_pkg::OFS_ISTAT, 32'h3F, 2'h0);
    wr(fpe_pkg::OFS_IMASK, 32'h07, 2'h0);
    wr(fpe_pkg::OFS_USE, 32'h3F, 2'h0);
    meas(16'h13BB, 16'h015E);
    hold_chk(6'h00, 500);
    meas(16'h13BB, 16'h015F);
    hold_chk(6'h00, 380);
    wait_trip(6'h08, 80);
    wr(fpe_pkg::OFS_USE, 32'h37, 2'h0);
    wait_trip(6'h00, 10);
    meas(16'h13ED, 16'h015F);
    wr(fpe_pkg::OFS_USE, 32'h3F, 2'h0);
    wait_trip(6'h18, 480);
    rd(fpe_pkg::OFS_STAT, 32'h1818, 2'h0);
    rd(fpe_pkg::OFS_ISTAT, 32'h18, 2'h0);
    chk(irq, 1'b0);
    wr(fpe_pkg::OFS_IMASK, 32'h3F, 2'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    meas(16'h1388, 16'h015F);
    hold_chk(6'h18, 780);
    wait_trip(6'h00, 80);
    rd(fpe_pkg::OFS_MEAS, 32'h015F1388, 2'h0);
    $display("test overfreq done");
    stop_test();
  end
endmodule
`default_nettype wire
